/* rtl/pss_defines.svh */
// Purpose: Offsets, signatures, category masks and reset values
// Assumes: Word address on the bus is {object index[15:0], subindex[3:0]}
// Notes: Definitions only
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Object indices (upper address bits)
`define PSS_OBJ_STORE 16'h1010
`define PSS_OBJ_DISCARD 16'h1011
`define PSS_OBJ_MARKER 16'h1020
`define PSS_OBJ_USER 16'h2700

// Subindex layout
`define PSS_SUB_ALL 4'h1
`define PSS_SUB_TUNING 4'h6
`define PSS_SUB_COUNT 32'h00000006
`define PSS_MARKER_LAST 4'h2
`define PSS_USER_TRIG 4'h1
`define PSS_USER_FIRST 4'h2
`define PSS_USER_LAST 4'h9

// Trigger values
`define PSS_SIG_SAVE 32'h65766173
`define PSS_SIG_DISCARD 32'h64616F6C
`define PSS_DONE_VAL 32'h00000001
`define PSS_USER_GO 16'h0001

// Category mask bits: 0 comm, 1 app, 2 customer, 3 drive, 4 tuning, 5 user area, 6 marker
`define PSS_CAT_STORE_ALL 7'h5F
`define PSS_CAT_FACTORY 7'h4F
`define PSS_CAT_BOOT 7'h7F
`define PSS_CAT_USER 7'h20
`define PSS_CAT_ONE 7'h01

// Reset values
`define PSS_RST_WORD 32'h00000000

`endif

/* rtl/pss_nv_sequencer.sv */
// Purpose: Hands one operation at a time to the nonvolatile store and reports its end
// Assumes: The store pulses nv_done_i once per request
// Notes: Leaves reset already asking for the boot reload
`timescale 1ns/10ps
`include "pss_defines.svh"
module pss_nv_sequencer (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Start request
    input wire logic start_i,
    input wire pss_pkg::pss_op_e op_i,
    input wire logic [6:0] cat_i,
    // Store side
    input wire logic nv_done_i,
    output logic nv_req_o,
    output pss_pkg::pss_op_e nv_op_o,
    output logic [6:0] nv_cat_o,
    // Completion
    output logic done_o
);
    // RULE2 boot reload
    // Reset leaves a load of every category pending, so no command is needed
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            nv_req_o <= 1'b1;
            nv_op_o <= pss_pkg::PSS_OP_LOAD;
            nv_cat_o <= `PSS_CAT_BOOT;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (nv_req_o) begin
                if (nv_done_i) begin
                    nv_req_o <= 1'b0;
                    done_o <= 1'b1;
                end
            // RULE17 one at a time
            end else if (start_i) begin
                nv_req_o <= 1'b1;
                nv_op_o <= op_i;
                nv_cat_o <= cat_i;
            end
        end
    end
endmodule : pss_nv_sequencer

/* rtl/pss_pkg.sv */
// Purpose: Types shared by the parameter store sequencer files
// Assumes: Nothing
// Notes: Constants live in pss_defines.svh
package pss_pkg;

    // Operation requested from the nonvolatile store
    typedef enum logic [1:0] {
        PSS_OP_LOAD,
        PSS_OP_SAVE,
        PSS_OP_ERASE
    } pss_op_e;

    // Who started the running operation
    typedef enum logic [1:0] {
        PSS_SRC_BOOT,
        PSS_SRC_STORE,
        PSS_SRC_DISCARD,
        PSS_SRC_USER
    } pss_src_e;

endpackage : pss_pkg

/* rtl/pss_store_ctrl.sv */
// Purpose: Store, discard, marker and user word objects behind an Avalon-MM slave
// Assumes: Word address {object[15:0], subindex[3:0]}; one outstanding bus request
// Notes: Every access answers two edges after it is seen; user words stall while the store is busy
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "pss_defines.svh"
// Summary of operation
// RULE1: Saving works on whole categories only, never on a single object.
// RULE2: After every reset the saved values are reloaded automatically.
// RULE3: Save signature written to a store subindex saves that category.
// RULE4: A finished save replaces the store subindex value with one.
// RULE5: Subindex 1 is all, then comm, app, customer, drive, tuning.
// RULE6: Discard signature written to a restore subindex deletes that category.
// RULE7: Factory discard through subindex 1 spares tuning; subindex 6 clears tuning.
// RULE8: The device restarts by itself once deletion is done.
// RULE9: Marker holds a written date and time, saved with save-all.
// RULE10: Writing any savable object clears the marker, except store-all and marker.
// RULE11: Master configures, writes the marker, then saves all categories.
// RULE12: After restart the master reads the marker; zero means modified.
// RULE13: User memory holds eight 16-bit savable words at subindices 2 to 9.
// RULE14: Writing one to user subindex 1 saves; it reads zero when done.
// RULE15: Master waits for completion and keeps power during a save.
// RULE16: A value other than the signature starts nothing.
// RULE17: No second operation starts before the running one completes.
module pss_store_ctrl (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [19:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Savable object written elsewhere in the dictionary
    input wire logic dict_write_i,
    // Nonvolatile store control
    output logic nv_req_o,
    output pss_pkg::pss_op_e nv_op_o,
    output logic [6:0] nv_cat_o,
    input wire logic nv_done_i,
    // Reload data during the boot load
    input wire logic nv_ld_valid_i,
    input wire logic [3:0] nv_ld_addr_i,
    input wire logic [31:0] nv_ld_data_i,
    // Snapshot fetch during a save
    input wire logic [3:0] nv_fetch_addr_i,
    output logic [31:0] nv_fetch_data_o,
    // Device restart request
    output logic restart_o
);
    logic [15:0] obj, user_trig, mem_q, mem_wdata;
    logic [3:0] sub;
    logic [31:0] store_val [6:1], discard_val [6:1], marker [2:1];
    logic [31:0] wr_val, rd_mux;
    logic pend, seq_done, mem_we;
    logic cat_sub, marker_sub, user_sub, stall, bus_wr;
    logic wr_store, wr_discard, wr_marker, wr_user_word, wr_user_trig;
    logic start_store, start_discard, start_user, start_any, savable_wr;
    logic [2:0] mem_waddr, mem_raddr, done_sub;
    logic [6:0] next_cat;
    pss_pkg::pss_op_e next_op;
    pss_pkg::pss_src_e src;

    // Merge written bytes over the old word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Address decode
    assign obj = avs_address[19:4];
    assign sub = avs_address[3:0];
    assign cat_sub = (sub >= `PSS_SUB_ALL) && (sub <= `PSS_SUB_TUNING);
    assign marker_sub = (sub >= 4'h1) && (sub <= `PSS_MARKER_LAST);
    assign user_sub = (obj == `PSS_OBJ_USER) && (sub >= `PSS_USER_FIRST) && (sub <= `PSS_USER_LAST);
    // The memory read port belongs to the fetch channel while the store is busy
    assign stall = user_sub && nv_req_o;
    assign bus_wr = avs_write && !avs_waitrequest;

    // Write strobes per object, taken at the answering edge
    assign wr_store = bus_wr && (obj == `PSS_OBJ_STORE) && cat_sub;
    assign wr_discard = bus_wr && (obj == `PSS_OBJ_DISCARD) && cat_sub;
    assign wr_marker = bus_wr && (obj == `PSS_OBJ_MARKER) && marker_sub;
    assign wr_user_word = bus_wr && user_sub;
    assign wr_user_trig = bus_wr && (obj == `PSS_OBJ_USER) && (sub == `PSS_USER_TRIG);
    always_comb begin
        wr_val = avs_writedata;
        if (obj == `PSS_OBJ_STORE && cat_sub) begin
            wr_val = be_merge(store_val[sub[2:0]], avs_writedata, avs_byteenable);
        end else if (obj == `PSS_OBJ_DISCARD && cat_sub) begin
            wr_val = be_merge(discard_val[sub[2:0]], avs_writedata, avs_byteenable);
        end else if (obj == `PSS_OBJ_MARKER && marker_sub) begin
            wr_val = be_merge(marker[sub[1:0]], avs_writedata, avs_byteenable);
        end else if (obj == `PSS_OBJ_USER) begin
            wr_val = be_merge({16'h0000, (sub == `PSS_USER_TRIG) ? user_trig : mem_q}, avs_writedata,
                              avs_byteenable);
        end
    end

    // RULE16 signature match
    // RULE17 idle store only
    assign start_store = wr_store && (wr_val == `PSS_SIG_SAVE) && !nv_req_o;
    assign start_discard = wr_discard && (wr_val == `PSS_SIG_DISCARD) && !nv_req_o;
    assign start_user = wr_user_trig && (wr_val[15:0] == `PSS_USER_GO) && !nv_req_o;
    assign start_any = start_store || start_discard || start_user;

    // RULE1 whole categories
    // RULE5 subindex to category
    // RULE7 factory spares tuning
    always_comb begin
        next_op = pss_pkg::PSS_OP_SAVE;
        next_cat = `PSS_CAT_USER;
        if (start_store || start_discard) begin
            next_op = start_discard ? pss_pkg::PSS_OP_ERASE : pss_pkg::PSS_OP_SAVE;
            if (sub == `PSS_SUB_ALL) begin
                next_cat = start_discard ? `PSS_CAT_FACTORY : `PSS_CAT_STORE_ALL;
            end else begin
                next_cat = `PSS_CAT_ONE << (sub - 4'h2);
            end
        end
    end

    pss_nv_sequencer u_seq (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(start_any),
        .op_i(next_op),
        .cat_i(next_cat),
        .nv_done_i(nv_done_i),
        .nv_req_o(nv_req_o),
        .nv_op_o(nv_op_o),
        .nv_cat_o(nv_cat_o),
        .done_o(seq_done)
    );

    // Remember who started the operation so completion lands in the right place
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            src <= pss_pkg::PSS_SRC_BOOT;
            done_sub <= 3'h0;
        end else if (start_any) begin
            src <= start_store ? pss_pkg::PSS_SRC_STORE :
                   start_discard ? pss_pkg::PSS_SRC_DISCARD : pss_pkg::PSS_SRC_USER;
            done_sub <= sub[2:0];
        end
    end

    // RULE3 save trigger
    // RULE4 completion value
    // Completion is applied last so it wins over a write in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 1; i <= 6; i++) begin
                store_val[i] <= `PSS_RST_WORD;
            end
        end else begin
            if (wr_store && !nv_req_o) begin
                store_val[sub[2:0]] <= wr_val;
            end
            if (seq_done && src == pss_pkg::PSS_SRC_STORE) begin
                store_val[done_sub] <= `PSS_DONE_VAL;
            end
        end
    end

    // RULE6 discard trigger
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 1; i <= 6; i++) begin
                discard_val[i] <= `PSS_RST_WORD;
            end
        end else begin
            if (wr_discard && !nv_req_o) begin
                discard_val[sub[2:0]] <= wr_val;
            end
            if (seq_done && src == pss_pkg::PSS_SRC_DISCARD) begin
                discard_val[done_sub] <= `PSS_DONE_VAL;
            end
        end
    end

    // RULE8 restart after discard
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            restart_o <= 1'b0;
        end else begin
            restart_o <= seq_done && (src == pss_pkg::PSS_SRC_DISCARD);
        end
    end

    // RULE10 marker clear sources
    assign savable_wr = dict_write_i || wr_user_word || wr_user_trig ||
                        (bus_wr && (obj == `PSS_OBJ_STORE) && cat_sub && (sub != `PSS_SUB_ALL));

    // RULE9 marker date and time
    // A marker write in the clearing cycle is kept; the boot reload restores it
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            marker[1] <= `PSS_RST_WORD;
            marker[2] <= `PSS_RST_WORD;
        end else begin
            // RULE10 clear on savable write
            if (savable_wr) begin
                marker[1] <= `PSS_RST_WORD;
                marker[2] <= `PSS_RST_WORD;
            end
            if (wr_marker) begin
                marker[sub[1:0]] <= wr_val;
            end
            if (nv_ld_valid_i && nv_req_o && nv_op_o == pss_pkg::PSS_OP_LOAD &&
                (nv_ld_addr_i == 4'h1 || nv_ld_addr_i == 4'h2)) begin
                marker[nv_ld_addr_i[1:0]] <= nv_ld_data_i;
            end
        end
    end

    // RULE14 user save trigger
    // A start in the completion cycle wins, as a save is then running
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            user_trig <= 16'h0000;
        end else if (start_user) begin
            user_trig <= `PSS_USER_GO;
        end else if (seq_done && src == pss_pkg::PSS_SRC_USER) begin
            user_trig <= 16'h0000;
        end
    end

    // RULE13 user words
    // Reload data take the write port during boot; bus writes cannot collide as they stall then
    assign mem_we = (nv_ld_valid_i && nv_req_o && nv_ld_addr_i[3]) || wr_user_word;
    assign mem_waddr = nv_ld_valid_i ? nv_ld_addr_i[2:0] : 3'(sub - `PSS_USER_FIRST);
    assign mem_wdata = nv_ld_valid_i ? nv_ld_data_i[15:0] : wr_val[15:0];
    assign mem_raddr = nv_req_o ? nv_fetch_addr_i[2:0] : 3'(sub - `PSS_USER_FIRST);

    pss_user_mem u_mem (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_q)
    );

    // Snapshot for the store: marker at 1 and 2, user words at 8 to 15
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            nv_fetch_data_o <= `PSS_RST_WORD;
        end else if (nv_fetch_addr_i[3]) begin
            nv_fetch_data_o <= {16'h0000, mem_q};
        end else if (nv_fetch_addr_i == 4'h1 || nv_fetch_addr_i == 4'h2) begin
            nv_fetch_data_o <= marker[nv_fetch_addr_i[1:0]];
        end else begin
            nv_fetch_data_o <= `PSS_RST_WORD;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = `PSS_RST_WORD;
        if ((obj == `PSS_OBJ_STORE || obj == `PSS_OBJ_DISCARD) && sub == 4'h0) begin
            rd_mux = `PSS_SUB_COUNT;
        end else if (obj == `PSS_OBJ_STORE && cat_sub) begin
            rd_mux = store_val[sub[2:0]];
        end else if (obj == `PSS_OBJ_DISCARD && cat_sub) begin
            rd_mux = discard_val[sub[2:0]];
        end else if (obj == `PSS_OBJ_MARKER && marker_sub) begin
            rd_mux = marker[sub[1:0]];
        end else if (obj == `PSS_OBJ_USER && sub == `PSS_USER_TRIG) begin
            rd_mux = {16'h0000, user_trig};
        end else if (user_sub) begin
            rd_mux = {16'h0000, mem_q};
        end
    end

    // Bus handshake: one edge to settle the memory read, one to answer
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `PSS_RST_WORD;
            pend <= 1'b0;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (pend) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_mux;
            pend <= 1'b0;
        end else if ((avs_read || avs_write) && !stall) begin
            pend <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_bus_answer_two: assert property ((avs_read || avs_write) && avs_waitrequest && !pend && !stall
        |=> pend ##1 !avs_waitrequest)
        else $error("bus request not answered two edges later");
    a_save_sets_one: assert property (seq_done && src == pss_pkg::PSS_SRC_STORE |=> // RULE4
        store_val[$past(done_sub)] == `PSS_DONE_VAL)
        else $error("finished save did not write one");
    a_sig_starts_save: assert property (wr_store && wr_val == `PSS_SIG_SAVE && !nv_req_o |=> // RULE3
        nv_req_o && nv_op_o == pss_pkg::PSS_OP_SAVE)
        else $error("save signature did not start a save");
    a_bad_sig_idle: assert property (bus_wr && !start_any && !nv_req_o |=> !nv_req_o) // RULE16
        else $error("non-signature write started an operation");
    a_factory_no_tune: assert property (start_discard && sub == `PSS_SUB_ALL |=> // RULE7
        nv_cat_o == `PSS_CAT_FACTORY && !nv_cat_o[4])
        else $error("factory discard touched tuning");
    a_erase_restarts: assert property (seq_done && src == pss_pkg::PSS_SRC_DISCARD |=> restart_o) // RULE8
        else $error("no restart after discard");
    a_marker_cleared: assert property (dict_write_i && !wr_marker && !nv_ld_valid_i |=> // RULE10
        marker[1] == `PSS_RST_WORD && marker[2] == `PSS_RST_WORD)
        else $error("marker kept after savable write");
    a_user_trig_zero: assert property (seq_done && src == pss_pkg::PSS_SRC_USER && !start_user |=> // RULE14
        user_trig == 16'h0000)
        else $error("user trigger not cleared on completion");
    a_busy_holds_job: assert property (nv_req_o && !nv_done_i |=> nv_req_o && $stable(nv_cat_o) && $stable(src)) // RULE17
        else $error("operation changed while running");
    a_boot_reload: assert property ($fell(sys_rst_i) |-> nv_req_o && nv_op_o == pss_pkg::PSS_OP_LOAD && // RULE2
        nv_cat_o == `PSS_CAT_BOOT)
        else $error("no reload after reset");

    c_save_all: cover property (start_store && sub == `PSS_SUB_ALL ##[1:50] seq_done);
    c_discard_restart: cover property (start_discard ##[1:50] restart_o);
    c_user_save: cover property (start_user ##[1:50] seq_done && src == pss_pkg::PSS_SRC_USER);
    c_bad_signature: cover property (wr_store && !start_store && !nv_req_o);
endmodule : pss_store_ctrl

/* rtl/pss_user_mem.sv */
// Purpose: Eight 16-bit user words with one write port and a registered read port
// Assumes: Single clock, synchronous reset
// Notes: Read data lag the address by one edge
`timescale 1ns/10ps
module pss_user_mem (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [2:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    // Read port
    input wire logic [2:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] words [8];

    // Storage, cleared so a read before any load is defined
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 8; i++) begin
                words[i] <= 16'h0000;
            end
        end else if (wr_en_i) begin
            words[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 16'h0000;
        end else begin
            rd_data_o <= words[rd_addr_i];
        end
    end
endmodule : pss_user_mem

/* tb/pss_nv_model.sv */
// Purpose: Behavioural nonvolatile store facing the sequencer
// Assumes: One operation at a time, announced by nv_req_i
// Notes: The image survives reset; delay_i sets the answer delay
`timescale 1ns/10ps
module pss_nv_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Operation request
    input wire logic nv_req_i,
    input wire pss_pkg::pss_op_e nv_op_i,
    input wire logic [6:0] nv_cat_i,
    input wire logic [7:0] delay_i,
    output logic nv_done_o,
    // Reload and fetch channels
    output logic nv_ld_valid_o,
    output logic [3:0] nv_ld_addr_o,
    output logic [31:0] nv_ld_data_o,
    output logic [3:0] nv_fetch_addr_o,
    input wire logic [31:0] nv_fetch_data_i
);
    logic [31:0] img [16];

    // Marker slots need mask bit 6, user slots bit 5
    function automatic logic hit(input int a, input logic [6:0] c);
        return (a >= 1 && a <= 2 && c[6]) || (a >= 8 && c[5]);
    endfunction : hit

    // One operation per request; idle load data show the inverse
    initial begin
        foreach (img[k]) img[k] = 32'h0;
        nv_done_o = 1'b0;
        nv_ld_valid_o = 1'b0;
        nv_ld_addr_o = 4'h0;
        nv_ld_data_o = 32'hFFFFFFFF;
        nv_fetch_addr_o = 4'h0;
        forever begin
            @(posedge core_clk_i);
            if (nv_req_i === 1'b1 && sys_rst_i === 1'b0) begin
                repeat (delay_i) @(posedge core_clk_i);
                for (int i = 1; i < 16; i++) begin
                    if (!hit(i, nv_cat_i)) continue;
                    if (nv_op_i == pss_pkg::PSS_OP_LOAD) begin
                        nv_ld_addr_o <= i[3:0];
                        nv_ld_data_o <= img[i];
                        nv_ld_valid_o <= 1'b1;
                        @(posedge core_clk_i);
                    end else if (nv_op_i == pss_pkg::PSS_OP_SAVE) begin
                        nv_fetch_addr_o <= i[3:0];
                        repeat (3) @(posedge core_clk_i);
                        img[i] = nv_fetch_data_i;
                    end else begin
                        img[i] = 32'h0;
                    end
                end
                nv_ld_valid_o <= 1'b0;
                nv_ld_data_o <= ~nv_ld_data_o;
                nv_done_o <= 1'b1;
                @(posedge core_clk_i);
                nv_done_o <= 1'b0;
            end
        end
    end
endmodule : pss_nv_model

/* tb/pss_store_ctrl_tb.sv */
// Purpose: Self-checking bench for the parameter store objects
// Assumes: Store model answers every request
// Notes: Byte lanes stay all enabled; each wait is bounded
`timescale 1ns/10ps
`include "pss_defines.svh"
module pss_store_ctrl_tb;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [19:0] avs_address = 20'h00000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic dict_write_i = 1'b0;
    logic [7:0] nv_delay = 8'h03;
    logic avs_waitrequest, nv_req_o, nv_done_i, nv_ld_valid_i, restart_o;
    logic [31:0] avs_readdata, nv_ld_data_i, nv_fetch_data_o, rd;
    logic [3:0] nv_ld_addr_i, nv_fetch_addr_i;
    logic [6:0] nv_cat_o;
    pss_pkg::pss_op_e nv_op_o;
    int num_errors = 0, checked = 0, restarts = 0, n;

    pss_store_ctrl uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dict_write_i(dict_write_i), .nv_req_o(nv_req_o), .nv_op_o(nv_op_o), .nv_cat_o(nv_cat_o),
        .nv_done_i(nv_done_i), .nv_ld_valid_i(nv_ld_valid_i), .nv_ld_addr_i(nv_ld_addr_i),
        .nv_ld_data_i(nv_ld_data_i), .nv_fetch_addr_i(nv_fetch_addr_i),
        .nv_fetch_data_o(nv_fetch_data_o), .restart_o(restart_o));
    pss_nv_model nv (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .nv_req_i(nv_req_o), .nv_op_i(nv_op_o),
        .nv_cat_i(nv_cat_o), .delay_i(nv_delay), .nv_done_o(nv_done_i), .nv_ld_valid_o(nv_ld_valid_i),
        .nv_ld_addr_o(nv_ld_addr_i), .nv_ld_data_o(nv_ld_data_i), .nv_fetch_addr_o(nv_fetch_addr_i),
        .nv_fetch_data_i(nv_fetch_data_o));

    // Clock and restart pulse counter
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (restart_o === 1'b1) restarts <= restarts + 1;

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One bus access, then one idle edge before the next
    task automatic bus(input logic wr, input logic [15:0] obj, input logic [3:0] sub, input logic [31:0] d);
        avs_address <= {obj, sub};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 300);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 300) begin
            num_errors++;
            finish_test();
        end
        @(posedge core_clk_i);
    endtask : bus

    task automatic rdc(input logic [15:0] obj, input logic [3:0] sub, input logic [31:0] exp);
        bus(1'b0, obj, sub, 32'h00000000);
        chk($sformatf("read %h:%h", obj, sub), rd, exp);
    endtask : rdc

    task automatic opchk(input pss_pkg::pss_op_e op, input logic [6:0] cat);
        chk("busy", {31'h0, nv_req_o}, 32'h00000001);
        chk("operation", {30'h0, nv_op_o}, {30'h0, op});
        chk("category", {25'h0, nv_cat_o}, {25'h0, cat});
    endtask : opchk

    // Completion, then two edges for the restart count
    task automatic wait_idle();
        n = 0;
        while (nv_req_o !== 1'b0 && n < 500) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 500) begin
            num_errors++;
            finish_test();
        end
        repeat (2) @(posedge core_clk_i);
    endtask : wait_idle

    task automatic rst();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        chk("waitrequest", {31'h0, avs_waitrequest}, 32'h00000001);
        opchk(pss_pkg::PSS_OP_LOAD, `PSS_CAT_BOOT);
        wait_idle();
    endtask : rst

    // Main sequence
    initial begin
        rst();
        rdc(`PSS_OBJ_STORE, 4'h0, `PSS_SUB_COUNT);
        rdc(`PSS_OBJ_DISCARD, 4'h0, `PSS_SUB_COUNT);
        rdc(`PSS_OBJ_STORE, `PSS_SUB_ALL, 32'h00000000);
        rdc(16'h3000, 4'h1, 32'h00000000);
        $display("reset test done");
        for (int s = 1; s <= 6; s++) begin
            nv_delay <= s[0] ? 8'h00 : 8'h28;
            bus(1'b1, `PSS_OBJ_STORE, s[3:0], `PSS_SIG_SAVE);
            opchk(pss_pkg::PSS_OP_SAVE, (s == 1) ? `PSS_CAT_STORE_ALL : 7'(`PSS_CAT_ONE << (s - 2)));
            wait_idle();
            rdc(`PSS_OBJ_STORE, s[3:0], `PSS_DONE_VAL);
        end
        chk("restarts", 32'(restarts), 32'h00000000);
        $display("store test done");
        for (int s = 1; s <= 6; s++) begin
            bus(1'b1, `PSS_OBJ_DISCARD, s[3:0], `PSS_SIG_DISCARD);
            opchk(pss_pkg::PSS_OP_ERASE, (s == 1) ? `PSS_CAT_FACTORY : 7'(`PSS_CAT_ONE << (s - 2)));
            wait_idle();
            chk("restarts", 32'(restarts), 32'(s));
            rdc(`PSS_OBJ_DISCARD, s[3:0], `PSS_DONE_VAL);
        end
        $display("discard test done");
        bus(1'b1, `PSS_OBJ_MARKER, 4'h1, 32'h00012345);
        bus(1'b1, `PSS_OBJ_MARKER, 4'h2, 32'h00006789);
        rdc(`PSS_OBJ_MARKER, 4'h1, 32'h00012345);
        bus(1'b1, `PSS_OBJ_STORE, 4'h3, `PSS_SIG_SAVE ^ 32'h00000001);
        chk("busy", {31'h0, nv_req_o}, 32'h00000000);
        rdc(`PSS_OBJ_STORE, 4'h3, `PSS_SIG_SAVE ^ 32'h00000001);
        rdc(`PSS_OBJ_MARKER, 4'h2, 32'h00000000);
        bus(1'b1, `PSS_OBJ_MARKER, 4'h1, 32'h00012345);
        bus(1'b1, `PSS_OBJ_MARKER, 4'h2, 32'h00006789);
        bus(1'b1, `PSS_OBJ_STORE, `PSS_SUB_ALL, `PSS_SIG_SAVE);
        wait_idle();
        rdc(`PSS_OBJ_MARKER, 4'h1, 32'h00012345);
        rst();
        rdc(`PSS_OBJ_MARKER, 4'h1, 32'h00012345);
        rdc(`PSS_OBJ_MARKER, 4'h2, 32'h00006789);
        dict_write_i <= 1'b1;
        @(posedge core_clk_i);
        dict_write_i <= 1'b0;
        rdc(`PSS_OBJ_MARKER, 4'h1, 32'h00000000);
        $display("marker test done");
        for (int w = 2; w <= 9; w++) bus(1'b1, `PSS_OBJ_USER, w[3:0], 32'hA000 + w);
        nv_delay <= 8'h28;
        bus(1'b1, `PSS_OBJ_USER, `PSS_USER_TRIG, 32'(`PSS_USER_GO));
        opchk(pss_pkg::PSS_OP_SAVE, `PSS_CAT_USER);
        rdc(`PSS_OBJ_USER, `PSS_USER_TRIG, 32'h00000001);
        bus(1'b1, `PSS_OBJ_DISCARD, 4'h6, `PSS_SIG_DISCARD);
        opchk(pss_pkg::PSS_OP_SAVE, `PSS_CAT_USER);
        wait_idle();
        chk("restarts", 32'(restarts), 32'h00000006);
        rdc(`PSS_OBJ_USER, `PSS_USER_TRIG, 32'h00000000);
        rst();
        for (int w = 2; w <= 9; w++) rdc(`PSS_OBJ_USER, w[3:0], 32'hA000 + w);
        $display("user memory test done");
        finish_test();
    end
endmodule : pss_store_ctrl_tb
